// ---- rtl/hub_strap_params.svh ----
// Constants for the hub strap and indicator pin block
`ifndef HUB_STRAP_PARAMS_SVH
`define HUB_STRAP_PARAMS_SVH

// Number of downstream ports
`define HS_PORT_COUNT      4
// Configuration-select encodings (sel1 sel0)
`define HS_CFG_SMB_A       2'b00
`define HS_CFG_SMB_B       2'b01
`define HS_CFG_INTERNAL    2'b10
`define HS_CFG_EEPROM      2'b11
// Slave addresses for the two serial-slave choices
`define HS_SMB_ADDR_A      7'h2C
`define HS_SMB_ADDR_B      7'h2D
// Reset value of the sampled polarity: active high
`define HS_POL_RESET       1'b1

`endif

// ---- rtl/hub_strap_pkg.sv ----
// Types shared by the hub strap and indicator pin block
package hub_strap_pkg;

  // Ways the hub may be configured
  typedef enum logic [2:0]
  {
    CFG_SMBUS_A     = 3'b000,
    CFG_SMBUS_B     = 3'b001,
    CFG_DEFAULT     = 3'b010,
    CFG_DEFAULT_STR = 3'b011,
    CFG_EEPROM      = 3'b100
  } config_source_type;

  // Everything captured at reset release
  typedef struct packed
  {
    logic              indicator_support_strap;
    logic              multi_translator_strap;
    logic              gang_power_strap;
    logic              power_polarity_strap;
    config_source_type source;
  } strap_set_type;

endpackage

// ---- rtl/hub_strap_led_config.sv ----
// Reset-time strap capture and amber LED / port power pin logic
//
// Contract
// - Port-4 strap sets LED support only
// - Port-3 amber LED always active low
// - Register-configured LEDs 4,2,1 active low
// - Port-2 strap picks translators, LED polarity
// - Port-1 strap picks gang, LED polarity
// - In reset, power polarity follows strap
// - Polarity latched at reset release
// - Strap high means power active high
// - Select pins sampled at reset release
// - Select encoding picks configuration source
`timescale 1ns/1ps
`include "hub_strap_params.svh"

module hub_strap_led_config
  import hub_strap_pkg::*;
#(
  parameter int PORTS = `HS_PORT_COUNT  // Downstream port count
)
(
  input  wire logic               clk_sys,                // Core clock, 10 MHz
  input  wire logic               sys_rst,                // Synchronous reset, high
  // Shared amber LED / strap pins (in, out, enable; port 3 has no input)
  input  wire logic               amber_led_p4_in,
  output logic                    amber_led_p4_out,
  output logic                    amber_led_p4_oe,
  output logic                    amber_led_p3_out,
  output logic                    amber_led_p3_oe,
  input  wire logic               amber_led_p2_in,
  output logic                    amber_led_p2_out,
  output logic                    amber_led_p2_oe,
  input  wire logic               amber_led_p1_in,
  output logic                    amber_led_p1_out,
  output logic                    amber_led_p1_oe,
  // Logical indicator requests from the hub core
  input  wire logic [3:0]         amber_on,
  // Core-side LED support when configured by register load
  input  wire logic               reg_led_support,
  // Straps for power polarity and configuration source
  input  wire logic               power_polarity_strap,
  input  wire logic               config_select_b0,
  input  wire logic               config_select_b1,
  input  wire logic               config_select_b2,
  // Port power requests and pins
  input  wire logic [PORTS-1:0]   power_request,
  output logic      [PORTS-1:0]   port_power_enable,
  // Overcurrent sense, low active, from monitors
  input  wire logic [PORTS-1:0]   overcurrent_sense_n,
  output logic      [PORTS-1:0]   overcurrent,
  // Captured configuration
  output strap_set_type           straps,
  output logic                    straps_valid,
  output logic                    smb_slave_mode,
  output logic      [6:0]         smb_slave_addr
);

  // ************************************************
  // Strap capture
  // ************************************************

  strap_set_type straps_q;  // Captured straps
  strap_set_type straps_d;  // Next captured straps
  logic          valid_q;   // Straps captured since reset
  logic          valid_d;   // Next valid
  logic          in_rst_q;  // Previous cycle was in reset
  logic          in_rst_d;  // Next reset tracker

  // Decode three select pins into a source
  function automatic config_source_type decode_source(input logic [2:0] sel);
    // Select encoding table
    case (sel[1:0])
      `HS_CFG_SMB_A:    decode_source = CFG_SMBUS_A;
      `HS_CFG_SMB_B:    decode_source = CFG_SMBUS_B;
      `HS_CFG_INTERNAL: decode_source = sel[2] ? CFG_DEFAULT_STR : CFG_DEFAULT;
      default:          decode_source = CFG_EEPROM;
    endcase
  endfunction

  // Capture on the first cycle after reset drops
  always_comb
  begin
    straps_d = straps_q;
    valid_d  = valid_q;
    in_rst_d = sys_rst;
    if (sys_rst)
    begin
      // Nothing captured in reset; straps_q keeps its reset value, pins released meanwhile
      valid_d = 1'b0;
    end
    else if (in_rst_q)
    begin
      straps_d.source = decode_source({config_select_b2, config_select_b1, config_select_b0});
      straps_d.indicator_support_strap = amber_led_p4_in;
      straps_d.multi_translator_strap  = amber_led_p2_in;
      straps_d.gang_power_strap        = amber_led_p1_in;
      straps_d.power_polarity_strap    = power_polarity_strap;
      valid_d = 1'b1;
    end
  end

  // Register the strap group
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      straps_q <= '{1'b0, 1'b0, 1'b0, `HS_POL_RESET, CFG_DEFAULT};
      valid_q  <= 1'b0;
      in_rst_q <= 1'b1;
    end
    else
    begin
      straps_q <= straps_d;
      valid_q  <= valid_d;
      in_rst_q <= in_rst_d;
    end
  end

  assign straps       = straps_q;
  assign straps_valid = valid_q;

  assign smb_slave_mode = valid_q && (straps_q.source == CFG_SMBUS_A || straps_q.source == CFG_SMBUS_B);
  assign smb_slave_addr = (straps_q.source == CFG_SMBUS_B) ? `HS_SMB_ADDR_B : `HS_SMB_ADDR_A;

  // ************************************************
  // Port power
  // ************************************************

  logic pol_active;  // Active level of power pins

  assign pol_active = (sys_rst || !valid_q) ? power_polarity_strap : straps_q.power_polarity_strap;

  always_comb
  begin
    for (int i = 0; i < PORTS; i++)
    begin
      // Power forced off in reset and until straps are valid; valid_q lags reset by one edge
      port_power_enable[i] = (power_request[i] && valid_q && !sys_rst) ? pol_active : ~pol_active;
    end
  end

  assign overcurrent = ~overcurrent_sense_n;

  // ************************************************
  // Amber LEDs
  // ************************************************

  logic internal_cfg;  // Strap-driven configuration in use
  logic led_enable;    // LEDs may light

  assign internal_cfg = (straps_q.source == CFG_DEFAULT) || (straps_q.source == CFG_DEFAULT_STR);
  assign led_enable   = valid_q && (internal_cfg ? straps_q.indicator_support_strap : reg_led_support);

  // LED pins stay released in reset so straps can be read
  always_comb
  begin
    // Released from the very first reset cycle, not one edge later
    amber_led_p4_oe = valid_q && !sys_rst;
    amber_led_p3_oe = valid_q && !sys_rst;
    amber_led_p2_oe = valid_q && !sys_rst;
    amber_led_p1_oe = valid_q && !sys_rst;
    amber_led_p3_out = ~(amber_on[2] && led_enable);
    amber_led_p4_out = ~(amber_on[3] && led_enable);
    amber_led_p2_out = ~(amber_on[1] && led_enable);
    amber_led_p1_out = ~(amber_on[0] && led_enable);
    if (internal_cfg)
    begin
      // Disabled support keeps LED off (high if active low, low if its strap selects active high)
      amber_led_p4_out = ~(amber_on[3] && led_enable);
      amber_led_p2_out = straps_q.multi_translator_strap ? ~(amber_on[1] && led_enable)
                                                         : (amber_on[1] && led_enable);
      amber_led_p1_out = straps_q.gang_power_strap ? ~(amber_on[0] && led_enable)
                                                   : (amber_on[0] && led_enable);
    end
  end

  // ************************************************
  // Checks
  // ************************************************

  pol_release_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    $fell(in_rst_q) |-> straps_q.power_polarity_strap == $past(power_polarity_strap))
    else $error("Polarity not latched at release");
  pol_hold_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    valid_q && $past(valid_q) |-> $stable(straps_q))
    else $error("Straps changed after capture");
  pwr_reset_a: assert property (@(posedge clk_sys)
    sys_rst |-> port_power_enable == {PORTS{~power_polarity_strap}})
    else $error("Power enabled during reset");
  pwr_level_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    valid_q && power_request[0] |-> port_power_enable[0] == straps_q.power_polarity_strap)
    else $error("Power level wrong");
  sel_decode_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    $fell(in_rst_q) |-> straps_q.source == decode_source($past({config_select_b2, config_select_b1,
                                                                config_select_b0})))
    else $error("Select not captured");
  smb_addr_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    valid_q && straps_q.source == CFG_SMBUS_B |-> smb_slave_mode && smb_slave_addr == 7'h2D)
    else $error("Slave address wrong");
  am3_low_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    led_enable && amber_on[2] |-> !amber_led_p3_out)
    else $error("Port 3 LED not low");
  led_off_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    valid_q && internal_cfg && !straps_q.indicator_support_strap |-> amber_led_p4_out)
    else $error("Port 4 LED lit while disabled");
  stt_level_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    valid_q && internal_cfg && !straps_q.multi_translator_strap |-> amber_led_p2_out == (amber_on[1] && led_enable))
    else $error("Port 2 LED polarity wrong");
  gang_level_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    valid_q && internal_cfg && straps_q.gang_power_strap |-> amber_led_p1_out == !(amber_on[0] && led_enable))
    else $error("Port 1 LED polarity wrong");
  reg_led_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    valid_q && !internal_cfg && reg_led_support && amber_on[3] |-> !amber_led_p4_out)
    else $error("Port 4 LED not active low");

endmodule

// ---- bench/board_model.sv ----
// Board-side model: strap resistors, amber LEDs and current monitors
`timescale 1ns/1ps

module board_model
(
  input  wire logic       strap_p4,  // Resistor level on port-4 pin
  input  wire logic       strap_p2,  // Resistor level on port-2 pin
  input  wire logic       strap_p1,  // Resistor level on port-1 pin
  input  wire logic       out_p4,    // Device drive levels
  input  wire logic       out_p2,
  input  wire logic       out_p1,
  input  wire logic       oe_p4,     // Device drive enables
  input  wire logic       oe_p2,
  input  wire logic       oe_p1,
  input  wire logic [3:0] fault,     // Monitor sees overload
  output logic            pin_p4,    // Resolved pin levels
  output logic            pin_p2,
  output logic            pin_p1,
  output logic      [3:0] sense_n    // Monitor outputs
);
  // Device drive beats the weak strap resistor
  assign pin_p4 = oe_p4 ? out_p4 : strap_p4;
  assign pin_p2 = oe_p2 ? out_p2 : strap_p2;
  assign pin_p1 = oe_p1 ? out_p1 : strap_p1;
  assign sense_n = ~fault;  // Pull-up holds idle lines high
endmodule

// ---- bench/tb_hub_strap_led_config.sv ----
// Testbench for the strap capture and LED / power pin block
`timescale 1ns/1ps

module tb_hub_strap_led_config;
  import hub_strap_pkg::*;
  // ****************************************
  // Signals
  // ****************************************
  logic          clk_sys = 1'b0;     // 10 MHz core clock
  logic          sys_rst = 1'b1;     // Held at start
  logic          s4 = 0, s2 = 0, s1 = 0, pol = 0;  // Strap levels
  logic    [2:0] sel = 3'h0;         // Select straps
  logic    [3:0] amber_on = 4'h0;    // LED requests
  logic    [3:0] req = 4'h0;         // Power requests
  logic    [3:0] fault = 4'h0;       // Monitor faults
  logic          reg_led = 1'b1;     // Register-side LED support
  logic          pi4, pi2, pi1, o4, o3, o2, o1, e4, e3, e2, e1, valid, smb;
  logic    [3:0] ppe, oc, sense_n;
  logic    [6:0] addr;
  strap_set_type straps;
  int            failures = 0, check_count = 0, cycles = 0;

  always #50 clk_sys = ~clk_sys;

  hub_strap_led_config u_dut
  (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .amber_led_p4_in(pi4), .amber_led_p4_out(o4),
    .amber_led_p4_oe(e4), .amber_led_p3_out(o3), .amber_led_p3_oe(e3), .amber_led_p2_in(pi2),
    .amber_led_p2_out(o2), .amber_led_p2_oe(e2), .amber_led_p1_in(pi1), .amber_led_p1_out(o1),
    .amber_led_p1_oe(e1), .amber_on(amber_on), .reg_led_support(reg_led),
    .power_polarity_strap(pol), .config_select_b0(sel[0]), .config_select_b1(sel[1]),
    .config_select_b2(sel[2]), .power_request(req), .port_power_enable(ppe),
    .overcurrent_sense_n(sense_n), .overcurrent(oc), .straps(straps), .straps_valid(valid),
    .smb_slave_mode(smb), .smb_slave_addr(addr)
  );

  board_model u_board
  (
    .strap_p4(s4), .strap_p2(s2), .strap_p1(s1), .out_p4(o4), .out_p2(o2), .out_p1(o1),
    .oe_p4(e4), .oe_p2(e2), .oe_p1(e1), .fault(fault), .pin_p4(pi4), .pin_p2(pi2),
    .pin_p1(pi1), .sense_n(sense_n)
  );

  // ****************************************
  // Checking and closing
  // ****************************************
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // Expected source from select pins
  function automatic logic [2:0] exp_src(input logic [2:0] c);
    if (c == 3'b010) return CFG_DEFAULT;
    if (c == 3'b110) return CFG_DEFAULT_STR;
    if (c[1:0] == 2'b11) return CFG_EEPROM;
    return c[0] ? CFG_SMBUS_B : CFG_SMBUS_A;
  endfunction

  // ****************************************
  // One reset, capture and pin sweep
  // ****************************************
  task automatic run_cfg(input logic [3:0] k);
    logic       in_def, p0, en, c4, c2, c1;
    logic [3:0] a, x;
    begin
      @(negedge clk_sys);
      sys_rst = 1'b1;
      sel = k[2:0];
      s4 = k[3] | k[2];
      s2 = k[3];
      s1 = k[3] ^ k[2];
      pol = k[3] ^ k[1];
      req = 4'hF;
      reg_led = ~(k[3] & k[2]);
      p0 = pol;
      {c4, c2, c1} = {s4, s2, s1};
      in_def = (k[1:0] == 2'b10);
      // LED support: strap under internal config, register side otherwise
      en = in_def ? c4 : reg_led;
      #10;
      check("pwr_reset_entry", {4'h0, ppe}, {4'h0, {4{~pol}}});
      repeat (2) @(negedge clk_sys);
      check("pwr_in_reset", {4'h0, ppe}, {4'h0, {4{~pol}}});
      check("oe_in_reset", {4'h0, e4, e3, e2, e1}, 8'h00);
      sys_rst = 1'b0;
      repeat (2) @(negedge clk_sys);
      check("valid", {7'h0, valid}, 8'h01);
      check("source", {5'h0, straps.source}, {5'h0, exp_src(k[2:0])});
      check("smb_mode", {7'h0, smb}, {7'h0, ~k[1]});
      if (!k[1]) check("smb_addr", {1'b0, addr}, k[0] ? 8'h2D : 8'h2C);
      check("pol_strap", {7'h0, straps.power_polarity_strap}, {7'h0, p0});
      if (in_def) check("straps", {5'h0, straps[6:4]}, {5'h0, c4, c2, c1});
      // Later strap changes must not reach the captured set
      {s4, s2, s1, pol} = ~{s4, s2, s1, pol};
      sel = ~sel;
      for (int i = 0; i < 16; i++)
      begin
        a = i[3:0];
        amber_on = a;
        req = a;
        fault = a;
        #10;
        // Disabled support leaves every LED at its off level
        x[3] = ~(a[3] & en);
        x[2] = ~(a[2] & en);
        x[1] = (in_def && !c2) ? (a[1] & en) : ~(a[1] & en);
        x[0] = (in_def && !c1) ? (a[0] & en) : ~(a[0] & en);
        check("leds", {4'h0, o4, o3, o2, o1}, {4'h0, x});
        check("oe", {4'h0, e4, e3, e2, e1}, 8'h0F);
        check("power", {4'h0, ppe}, {4'h0, p0 ? a : ~a});
        check("overcurrent", {4'h0, oc}, {4'h0, a});
        @(negedge clk_sys);
      end
      check("held_src", {5'h0, straps.source}, {5'h0, exp_src(k[2:0])});
      check("held_pol", {7'h0, straps.power_polarity_strap}, {7'h0, p0});
      check("held_straps", {5'h0, straps[6:4]}, {5'h0, c4, c2, c1});
    end
  endtask

  // Cut a hang short
  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      failures++;
      conclude();
    end
  end

  initial
  begin
    repeat (2) @(negedge clk_sys);
    for (int k = 0; k < 16; k++)
      run_cfg(k[3:0]);
    conclude();
  end
endmodule
